// ---- iau_pkg.sv ----
// Constants and carrier types of the integer add unit.
// Assumes a single core clock domain and a plain strobe register port.
package iau_pkg;
  localparam int XLEN = 64;
  localparam int AW = 8;
  localparam int DW = 32;
  // Base encoding of the add family and the bits that must match it.
  localparam logic [31:0] ADD_BASE = 32'h7c000214;
  localparam logic [31:0] ADD_MASK = 32'hfc0003fe;
  // Instruction bit positions, numbered from the least significant bit.
  localparam int OE_POS = 10;
  localparam int REC_POS = 0;
  localparam int RD_POS = 21;
  localparam int SRCA_POS = 16;
  localparam int SRCB_POS = 11;
  // Mode mapping: 32-bit mode bit n equals 64-bit mode bit n + 32.
  localparam int MODE_SHIFT = 32;
  // Register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FXEXC = 8'h04;
  localparam logic [7:0] OFS_CFZ = 8'h08;
  localparam logic [7:0] OFS_STS = 8'h0c;
  localparam logic [7:0] OFS_MSK = 8'h10;
  // Field positions.
  localparam int CTRL_MODE32 = 0;
  localparam int FXEXC_OVF = 0;
  localparam int FXEXC_SUM = 1;
  localparam int EV_OVF = 0;
  localparam int EV_ILL = 1;
  localparam int NEV = 2;
  // Reset values.
  localparam logic [1:0] MSK_RST = 2'h0;
  localparam logic [3:0] CFZ_RST = 4'h0;

  typedef struct packed {
    logic valid;
    logic [31:0] inst;
    logic [XLEN-1:0] opA;
    logic [XLEN-1:0] opB;
  } iau_req_s;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [XLEN-1:0] data;
  } iau_wb_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } iau_bus_s;

  // Condition field layout: negative, positive, zero, summary overflow.
  typedef struct packed {
    logic neg;
    logic pos;
    logic zero;
    logic so;
  } iau_cfz_s;
endpackage : iau_pkg

// ---- integer_add_unit.sv ----
// Integer add unit: register-to-register add family with flag update.
// Assumes the decoder delivers the instruction word with both source
// operand values already read, and takes the writeback one cycle later.
//
// Overview of operation
// - The add family is recognised by its base opcode, ignoring the two variant bits.
// - Four variants exist, one for each setting of the overflow-enable and record bits.
// - Every variant writes source A plus source B to the destination register.
// - With the record bit set the condition field follows the result, otherwise it is kept.
// - With overflow-enable set the overflow and summary flags update, else they are kept.
// - Overflow uses all 64 sum bits in 64-bit mode and the low 32 bits in 32-bit mode.
// - Condition flags come from the truncated result, not the exact sum.
// - A 64-bit build leaves reset in 64-bit mode and also offers a 32-bit mode.
// - The mode is exported so addressing, condition setting and loop count tests follow it.
// - A 64-bit build keeps 64-bit wide operands and results.
// - A 32-bit build keeps 32-bit wide operands; the result keeps any carry into bit 32.
// - A 64-bit build executes the add family in both modes.
// - Words outside the provided instruction set are flagged illegal.
// - In 32-bit mode bit positions are the 64-bit positions less 32.
`timescale 1ns/1ps

module integer_add_unit #(
  parameter bit IMPL64 = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input iau_pkg::iau_req_s req,
  output iau_pkg::iau_wb_s wb,
  output logic illegal,
  output logic mode32,
  output iau_pkg::iau_cfz_s condField,
  output logic ovFlag,
  output logic sumOvFlag,
  input iau_pkg::iau_bus_s bus,
  output logic [iau_pkg::DW-1:0] rdata,
  output logic irq
);

  typedef struct packed {
    iau_pkg::iau_wb_s wb;
    logic illegal;
    logic mode32;
    iau_pkg::iau_cfz_s cfz;
    logic ovBit;
    logic so;
    logic [iau_pkg::NEV-1:0] sts;
    logic [iau_pkg::NEV-1:0] msk;
    logic [iau_pkg::DW-1:0] rdata;
    logic irq;
  } iau_state_s;

  localparam iau_state_s ST_RST = '{
    wb: '0,
    illegal: 1'b0,
    mode32: ~IMPL64,
    cfz: iau_pkg::CFZ_RST,
    ovBit: 1'b0,
    so: 1'b0,
    sts: '0,
    msk: iau_pkg::MSK_RST,
    rdata: '0,
    irq: 1'b0
  };

  iau_state_s st_ff;
  iau_state_s nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers.

  // Sign bit index for the active mode; 32-bit mode uses the 64-bit
  // position minus 32.
  function automatic int signPos(input logic m32);
    signPos = m32 ? (iau_pkg::XLEN - 1 - iau_pkg::MODE_SHIFT) : (iau_pkg::XLEN - 1);
  endfunction : signPos

  function automatic logic addOverflow(input logic [iau_pkg::XLEN-1:0] a,
                                       input logic [iau_pkg::XLEN-1:0] b,
                                       input logic [iau_pkg::XLEN-1:0] s,
                                       input logic m32);
    int p;
    p = signPos(m32);
    addOverflow = (a[p] == b[p]) && (s[p] != a[p]);
  endfunction : addOverflow

  ////////////////////////////////////////////////////////////////////////
  // Decode and datapath.

  logic isAdd;
  logic oeBit;
  logic recBit;
  logic modeNow;
  logic [iau_pkg::XLEN-1:0] opA;
  logic [iau_pkg::XLEN-1:0] opB;
  logic [iau_pkg::XLEN-1:0] sum;
  logic [iau_pkg::XLEN-1:0] low32;
  logic ovf;
  logic resNeg;
  logic resZero;

  assign isAdd = ((req.inst & iau_pkg::ADD_MASK) == iau_pkg::ADD_BASE);
  assign oeBit = req.inst[iau_pkg::OE_POS];
  assign recBit = req.inst[iau_pkg::REC_POS];
  assign modeNow = st_ff.mode32;
  assign low32 = {{(iau_pkg::XLEN-32){1'b0}}, {32{1'b1}}};
  // A 32-bit build never sees the upper half of its operands.
  assign opA = IMPL64 ? req.opA : (req.opA & low32);
  assign opB = IMPL64 ? req.opB : (req.opB & low32);
  assign sum = opA + opB;
  assign ovf = addOverflow(opA, opB, sum, modeNow);
  // Flags look at the wrapped result; an overflowed sum reads with the
  // wrong sign, which software must expect.
  assign resNeg = sum[signPos(modeNow)];
  assign resZero = modeNow ? (sum[31:0] == 32'h00000000) : (sum == '0);

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic exec;
    logic soNew;
    logic [iau_pkg::NEV-1:0] ev;
    exec = 1'b0;
    soNew = 1'b0;
    ev = '0;
    nxt_st = st_ff;
    nxt_st.wb.valid = 1'b0;
    nxt_st.illegal = 1'b0;
    nxt_st.rdata = '0;

    // Software writes first, so that hardware events below override them.
    if (bus.wr) begin
      if (bus.addr == iau_pkg::OFS_CTRL) begin
        // A 32-bit build has no 64-bit mode to enter.
        nxt_st.mode32 = IMPL64 ? bus.wdata[iau_pkg::CTRL_MODE32] : 1'b1;
      end else if (bus.addr == iau_pkg::OFS_FXEXC) begin
        nxt_st.ovBit = bus.wdata[iau_pkg::FXEXC_OVF];
        nxt_st.so = bus.wdata[iau_pkg::FXEXC_SUM];
      end else if (bus.addr == iau_pkg::OFS_STS) begin
        nxt_st.sts = st_ff.sts & ~bus.wdata[iau_pkg::NEV-1:0];
      end else if (bus.addr == iau_pkg::OFS_MSK) begin
        nxt_st.msk = bus.wdata[iau_pkg::NEV-1:0];
      end
    end

    if (req.valid) begin
      if (isAdd) begin
        exec = 1'b1;
      end else begin
        nxt_st.illegal = 1'b1;
        ev[iau_pkg::EV_ILL] = 1'b1;
      end
    end

    if (exec) begin
      nxt_st.wb.valid = 1'b1;
      nxt_st.wb.dest = req.inst[iau_pkg::RD_POS +: 5];
      nxt_st.wb.data = sum;
      // Without overflow-enable the condition field copies the summary flag as it
      // will stand after this edge, software write included, so both never disagree.
      soNew = nxt_st.so;
      if (oeBit) begin
        nxt_st.ovBit = ovf;
        soNew = st_ff.so | ovf;
        nxt_st.so = soNew;
        if (ovf) begin
          ev[iau_pkg::EV_OVF] = 1'b1;
        end
      end
      if (recBit) begin
        nxt_st.cfz.neg = resNeg;
        nxt_st.cfz.pos = ~resNeg & ~resZero;
        nxt_st.cfz.zero = resZero;
        nxt_st.cfz.so = soNew;
      end
    end

    // Events set status bits even when software clears them this cycle.
    nxt_st.sts = nxt_st.sts | ev;
    nxt_st.irq = |(nxt_st.sts & nxt_st.msk);

    if (bus.rd) begin
      if (bus.addr == iau_pkg::OFS_CTRL) begin
        nxt_st.rdata[iau_pkg::CTRL_MODE32] = st_ff.mode32;
      end else if (bus.addr == iau_pkg::OFS_FXEXC) begin
        nxt_st.rdata[iau_pkg::FXEXC_OVF] = st_ff.ovBit;
        nxt_st.rdata[iau_pkg::FXEXC_SUM] = st_ff.so;
      end else if (bus.addr == iau_pkg::OFS_CFZ) begin
        nxt_st.rdata[3:0] = st_ff.cfz;
      end else if (bus.addr == iau_pkg::OFS_STS) begin
        nxt_st.rdata[iau_pkg::NEV-1:0] = st_ff.sts;
      end else if (bus.addr == iau_pkg::OFS_MSK) begin
        nxt_st.rdata[iau_pkg::NEV-1:0] = st_ff.msk;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb = st_ff.wb;
  assign illegal = st_ff.illegal;
  assign mode32 = st_ff.mode32;
  assign condField = st_ff.cfz;
  assign ovFlag = st_ff.ovBit;
  assign sumOvFlag = st_ff.so;
  assign rdata = st_ff.rdata;
  assign irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic reqAdd;
  logic noSwExc;
  assign reqAdd = req.valid && isAdd;
  assign noSwExc = !(bus.wr && bus.addr == iau_pkg::OFS_FXEXC);

  sequence addIssued;
    reqAdd;
  endsequence

  sequence wbSeen;
    ##1 wb.valid;
  endsequence

  chk_add_writeback: assert property (addIssued |->
    wbSeen ##0 (wb.data == $past(sum)))
    else $error("add result not written back one cycle later");
  chk_nonadd_illegal: assert property (req.valid && !isAdd |=>
    illegal && !wb.valid)
    else $error("unrecognised word not flagged illegal");
  chk_cfz_hold: assert property (!(reqAdd && recBit) |=> $stable(condField))
    else $error("condition field changed without record bit");
  chk_cfz_zero: assert property (reqAdd && recBit && resZero |=>
    condField.zero && !condField.pos && !condField.neg)
    else $error("zero result not recorded");
  chk_ov_hold: assert property (!(reqAdd && oeBit) && noSwExc |=> $stable(ovFlag))
    else $error("overflow flag changed without overflow enable");
  chk_ov_mode: assert property (reqAdd && oeBit |=> ovFlag == $past(ovf))
    else $error("overflow flag does not follow the mode");
  chk_so_sticky: assert property (sumOvFlag && noSwExc |=> sumOvFlag)
    else $error("summary overflow dropped without software clear");
  chk_so_copy: assert property (reqAdd && recBit |=> condField.so == sumOvFlag)
    else $error("condition field does not copy summary overflow");
  chk_mode_rst: assert property ($rose(rst_n) |-> mode32 == ~IMPL64)
    else $error("wrong computation mode after reset");
  // An unmasked illegal event must raise the interrupt at the very next edge.
  chk_irq_level: assert property (req.valid && !isAdd && st_ff.msk[iau_pkg::EV_ILL] && !bus.wr
    |=> irq && st_ff.sts[iau_pkg::EV_ILL])
    else $error("unmasked event did not raise the interrupt");

endmodule : integer_add_unit

// ---- iau_decoder_model.sv ----
// Decoder model: hands one instruction word and both source values per go pulse.
// Assumes the bench raises go for one cycle per instruction.
`timescale 1ns/1ps
module iau_decoder_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [31:0] word,
  input wire logic [63:0] srcA,
  input wire logic [63:0] srcB,
  output iau_pkg::iau_req_s req
);
  // Idle lines toggle every cycle so a stale word is never mistaken for data.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
    end else begin
      req.valid <= go;
      req.inst <= go ? word : ~req.inst;
      req.opA <= go ? srcA : ~req.opA;
      req.opB <= go ? srcB : ~req.opB;
    end
  end
endmodule : iau_decoder_model

// ---- testbench.sv ----
// Testbench of the integer add unit: corner and random adds, flags, irq.
// Assumes the decoder model feeds requests and the bench owns the register port.
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [31:0] word = '0;
  logic [63:0] srcA = '0;
  logic [63:0] srcB = '0;
  iau_pkg::iau_bus_s bus = '0;
  iau_pkg::iau_req_s req;
  iau_pkg::iau_wb_s wb;
  iau_pkg::iau_cfz_s condField;
  logic illegal, mode32, ovFlag, sumOvFlag, irq;
  logic [31:0] rdata;
  int n_fail = 0;
  int total_checks = 0;
  logic eM32, eOv, eSo;
  logic [3:0] eCr;
  logic [1:0] eSts, eMsk;
  always #10 clk_sys = ~clk_sys;
  iau_decoder_model iau_decoder_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .go(go),
    .word(word), .srcA(srcA), .srcB(srcB), .req(req));
  integer_add_unit #(.IMPL64(1'b1)) integer_add_unit_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(req), .wb(wb), .illegal(illegal), .mode32(mode32), .condField(condField),
    .ovFlag(ovFlag), .sumOvFlag(sumOvFlag), .bus(bus), .rdata(rdata), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    chk(rdata, e);
  endtask : rd
  //////////////////////////////////////////////////////////////////////////////
  // Overflow-enable is big-endian bit 21, that is bit 10 counted from the right.
  function automatic logic [31:0] mk(input logic oe, input logic rc, input logic [4:0] d);
    return 32'h7c000214 | {6'h0, d, 21'h0} | ($urandom & 32'h001ff800)
      | (oe ? 32'h400 : 32'h0) | {31'h0, rc};
  endfunction : mk
  function automatic logic ovf(input logic [63:0] a, input logic [63:0] b, input logic m);
    logic [63:0] s;
    s = a + b;
    return m ? (a[31] == b[31] && s[31] != a[31]) : (a[63] == b[63] && s[63] != a[63]);
  endfunction : ovf
  task automatic send(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    int k;
    @(posedge clk_sys);
    go <= 1'b1;
    word <= w;
    srcA <= a;
    srcB <= b;
    @(posedge clk_sys);
    go <= 1'b0;
    k = 0;
    while (wb.valid !== 1'b1 && illegal !== 1'b1 && k < 4) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : send
  task automatic add_op(input logic oe, input logic rc, input logic [63:0] a,
                        input logic [63:0] b);
    logic [4:0] d;
    logic [63:0] s;
    logic ng, zr;
    d = 5'($urandom);
    s = a + b;
    ng = eM32 ? s[31] : s[63];
    zr = eM32 ? (s[31:0] == 32'h0) : (s == 64'h0);
    if (oe) begin
      eOv = ovf(a, b, eM32);
      eSo = eSo | eOv;
      eSts[0] = eSts[0] | eOv;
    end
    if (rc) eCr = {ng, !ng && !zr, zr, eSo};
    send(mk(oe, rc, d), a, b);
    chk(wb.valid, 1'b1);
    chk(wb.dest, d);
    chk(wb.data, s);
    chk(condField, eCr);
    chk({sumOvFlag, ovFlag}, {eSo, eOv});
    chk(irq, |(eSts & eMsk));
  endtask : add_op
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic m;
    void'($urandom(27));
    {eM32, eOv, eSo, eCr, eSts, eMsk} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(mode32, 1'b0);
    rd(iau_pkg::OFS_MSK, 32'h0);
    // Overflow events unmasked during the adds, so the interrupt check has teeth.
    wr(iau_pkg::OFS_MSK, 32'h1);
    eMsk = 2'h1;
    add_op(1'b1, 1'b1, 64'h7fffffffffffffff, 64'h1);
    add_op(1'b0, 1'b1, 64'h8000000000000000, 64'h8000000000000000);
    wr(iau_pkg::OFS_CTRL, 32'h1);
    eM32 = 1'b1;
    @(negedge clk_sys);
    chk(mode32, 1'b1);
    add_op(1'b1, 1'b1, 64'h000000007fffffff, 64'h1);
    add_op(1'b1, 1'b1, 64'hffffffff00000000, 64'h0);
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) begin
        m = 1'($urandom);
        wr(iau_pkg::OFS_CTRL, {31'h0, m});
        eM32 = m;
      end
      add_op(1'($urandom), 1'($urandom), {$urandom, $urandom}, {$urandom, $urandom});
    end
    send(32'h7c000014, 64'h1, 64'h2);
    chk(illegal, 1'b1);
    chk(wb.valid, 1'b0);
    eSts[1] = 1'b1;
    rd(iau_pkg::OFS_STS, {30'h0, eSts});
    chk(irq, |(eSts & eMsk));
    wr(iau_pkg::OFS_MSK, 32'h3);
    eMsk = 2'h3;
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(iau_pkg::OFS_STS, {30'h0, eSts});
    eSts = 2'h0;
    @(negedge clk_sys);
    chk(irq, 1'b0);
    send(32'h7c000014, 64'h3, 64'h4);
    eSts[1] = 1'b1;
    chk(illegal, 1'b1);
    chk(irq, |(eSts & eMsk));
    rd(iau_pkg::OFS_CFZ, {28'h0, eCr});
    rd(iau_pkg::OFS_FXEXC, {30'h0, eSo, eOv});
    wr(iau_pkg::OFS_FXEXC, 32'h0);
    rd(iau_pkg::OFS_FXEXC, 32'h0);
    rd(8'h20, 32'h0);
    complete_run();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule : testbench
